/* File: flash_pkg.sv */
// Constants, register map and carrier types of the flash map and erase control.
// Operation
// - The array is 32 bits wide so that one fetch returns a whole instruction.
// - Data in the array can be read as 16-bit operands selected by address bit 1.
// - After reset the array is decoded in segment 0, bytes 0 to 07fffh.
// - Before end of initialisation software may move the decode to segment 1, up to 17fffh.
// - After the end-of-initialisation instruction the segment mapping is locked.
// - The array is split into four banks ending at 02fffh, 05fffh, 077ffh and 07fffh.
// - An erase runs only in write/erase mode and clears only the selected bank.
// - A programmable timer sets the cycle length and a completion flag is set at its end.
// - A second flag reports whether the programming voltage stayed valid for the whole cycle.
// - Write/erase mode is entered only after the key sequence; other start attempts are rejected.
// - With security set, array accesses are allowed only from code running in the array.
// - Security may be disabled only from code in the array and only outside write/erase mode.
package flash_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_W = 32;
  localparam int WADDR_W = 13;
  localparam int BADDR_W = 18;
  // Timer tick length; one tick is a typical word write.
  localparam int TICK_US = 25;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
  // Byte end addresses of the banks in segment 0.
  localparam logic [17:0] BANK0_END = 18'h02fff;
  localparam logic [17:0] BANK1_END = 18'h05fff;
  localparam logic [17:0] BANK2_END = 18'h077ff;
  localparam logic [17:0] BANK3_END = 18'h07fff;
  localparam logic [2:0] SEG0_TAG = 3'h0;
  localparam logic [2:0] SEG1_TAG = 3'h2;
  // Register indices on the register port.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_KEY = 4'h1;
  localparam logic [3:0] REG_TIMER = 4'h2;
  localparam logic [3:0] REG_PDATA_LO = 4'h3;
  localparam logic [3:0] REG_PDATA_HI = 4'h4;
  localparam logic [3:0] REG_PADDR = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_SECDIS = 4'h7;
  // Control register fields.
  localparam int CTRL_SEG1 = 0;
  localparam int CTRL_BANK_LO = 1;
  localparam int CTRL_ERASE = 3;
  localparam int CTRL_START = 4;
  localparam int STAT_KEYERR = 7;
  localparam logic [15:0] KEY_FIRST = 16'h00a5;
  localparam logic [15:0] KEY_SECOND = 16'h005a;
  localparam logic [15:0] TIMER_RST = 16'h0001;
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffffffff;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_TIME} cyc_state_e;

  // CPU access toward the array.
  typedef struct packed {
    logic valid;
    logic fetch;
    logic from_flash;
    logic [BADDR_W-1:0] addr;
  } cpu_req_s;

  // Answer to an accepted CPU access, one cycle after it.
  typedef struct packed {
    logic valid;
    logic blocked;
    logic [WORD_W-1:0] fetch_data;
    logic [15:0] operand;
  } cpu_rsp_s;

  // Software-visible status bits.
  typedef struct packed {
    logic key_err;
    logic secure;
    logic seg1;
    logic locked;
    logic wem;
    logic busy;
    logic vpp_good;
    logic done;
  } status_s;
endpackage

/* File: flash_array.sv */
// Single-port 8K x 32 flash cell array with synchronous read.
`timescale 1ns/10ps
module flash_array (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [flash_pkg::WADDR_W-1:0] addr,
  input wire logic [flash_pkg::WORD_W-1:0] wdata,
  output logic [flash_pkg::WORD_W-1:0] rdata
);
  import flash_pkg::*;

  logic [WORD_W-1:0] mem [0:(1<<WADDR_W)-1];

  // Whole words are written and read so a fetch sees a full instruction.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // flash_array

/* File: flash_ctrl.sv */
// Flash map, program and bank erase control with register port and CPU port.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module flash_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire flash_pkg::cpu_req_s cpu_req,
  output logic cpu_ready,
  output flash_pkg::cpu_rsp_s cpu_rsp,
  input wire logic end_of_init_instruction,
  input wire logic vpp_ok,
  input wire logic sec_strap,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic reg_from_flash,
  output logic [15:0] reg_rdata
);
  import flash_pkg::*;

  cyc_state_e state_q;
  status_s stat;
  logic seg1_q, locked_q, wem_q, key_stage_q, secure_q, strap_taken_q;
  logic done_q, vpp_good_q, key_err_q, erase_q;
  logic [1:0] bank_q, bank_sel;
  logic [15:0] timer_q, ticks_q;
  logic [11:0] pre_q;
  logic [WORD_W-1:0] pdata_q, arr_wdata, arr_rdata;
  logic [WADDR_W-1:0] paddr_q, ptr_q, arr_addr, bank_lo, bank_hi;
  logic arr_we, start, start_ok, start_erase, tick, cyc_end, busy;
  logic hit, blocked, take, rsp_pend_q, rsp_blk_q, rsp_hi_q, rsp_fetch_q;

  assign busy = (state_q != ST_IDLE);
  assign start = reg_we && reg_addr == REG_CTRL && reg_wdata[CTRL_START];
  assign start_ok = start && wem_q && !busy;
  assign start_erase = start_ok && reg_wdata[CTRL_ERASE];
  assign tick = (pre_q == TICK_LAST);

  // Word range of the bank; a start write brings its own bank and mode.
  localparam logic [3:0][WADDR_W-1:0] BANK_LAST = {
    BANK3_END[WADDR_W+1:2], BANK2_END[WADDR_W+1:2],
    BANK1_END[WADDR_W+1:2], BANK0_END[WADDR_W+1:2]};
  assign bank_sel = start_ok ?
                    reg_wdata[CTRL_BANK_LO+1:CTRL_BANK_LO] : bank_q;
  assign bank_hi = BANK_LAST[bank_sel];
  assign bank_lo = (bank_sel == 2'd0) ? '0 :
                   WADDR_W'(BANK_LAST[bank_sel - 2'd1] + 1'b1);

  // Segment mapping: segment 0 from reset, segment 1 only until locked.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seg1_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      if (end_of_init_instruction) begin
        locked_q <= 1'b1;
      end
      if (reg_we && reg_addr == REG_CTRL && !locked_q &&
          !end_of_init_instruction) begin
        seg1_q <= reg_wdata[CTRL_SEG1];
      end
    end
  end

  // Key sequence arms write/erase mode; a wrong word disarms it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      key_stage_q <= 1'b0;
      wem_q <= 1'b0;
    end else if (reg_we && reg_addr == REG_KEY) begin
      key_stage_q <= (reg_wdata == KEY_FIRST);
      wem_q <= key_stage_q && reg_wdata == KEY_SECOND;
    end
  end

  // Security is taken from the strap after reset release; it can only be
  // dropped by code in the array while write/erase mode is off.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_taken_q <= 1'b0;
      secure_q <= 1'b1;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      secure_q <= sec_strap;
    end else if (reg_we && reg_addr == REG_SECDIS && reg_wdata[0] &&
                 reg_from_flash && !wem_q) begin
      secure_q <= 1'b0;
    end
  end

  // Plain configuration registers.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_q <= TIMER_RST;
      pdata_q <= ERASED_WORD;
      paddr_q <= '0;
      bank_q <= 2'd0;
      erase_q <= 1'b0;
    end else if (reg_we && !busy) begin
      unique case (reg_addr)
        REG_TIMER: timer_q <= reg_wdata;
        REG_PDATA_LO: pdata_q[15:0] <= reg_wdata;
        REG_PDATA_HI: pdata_q[31:16] <= reg_wdata;
        REG_PADDR: paddr_q <= reg_wdata[WADDR_W-1:0];
        REG_CTRL: begin
          bank_q <= reg_wdata[CTRL_BANK_LO+1:CTRL_BANK_LO];
          erase_q <= reg_wdata[CTRL_ERASE];
        end
        default: ;
      endcase
    end
  end

  // Cycle sequencer: erase sweeps the bank one word per clock, then the
  // timer runs out; a program cycle writes its word at start and times.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      ptr_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_erase) begin
            state_q <= ST_ERASE;
            ptr_q <= bank_lo;
          end else if (start_ok) begin
            state_q <= ST_TIME;
          end
        end
        ST_ERASE: begin
          ptr_q <= WADDR_W'(ptr_q + 1'b1);
          if (ptr_q == bank_hi) begin
            state_q <= ST_TIME;
          end
        end
        ST_TIME: begin
          if (cyc_end) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Tick prescaler and tick counter; a zero timer still takes one tick.
  // The timer keeps running under the sweep, so short settings still
  // finish only once the whole bank is cleared.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !busy) begin
      pre_q <= '0;
      ticks_q <= '0;
    end else begin
      pre_q <= tick ? '0 : 12'(pre_q + 1'b1);
      if (tick && ticks_q != 16'hffff) begin
        ticks_q <= 16'(ticks_q + 1'b1);
      end
    end
  end
  assign cyc_end = state_q == ST_TIME && tick &&
                   (16'(ticks_q + 1'b1) >= timer_q);

  // Completion, voltage and rejection flags.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      vpp_good_q <= 1'b0;
      key_err_q <= 1'b0;
    end else begin
      if (start_ok) begin
        done_q <= 1'b0;
        vpp_good_q <= vpp_ok;
      end else if (cyc_end) begin
        done_q <= 1'b1;
      end
      if (busy && !vpp_ok) begin
        vpp_good_q <= 1'b0;
      end
      // A new rejection in the clearing cycle wins over the clear.
      if (start && !start_ok) begin
        key_err_q <= 1'b1;
      end else if (reg_we && reg_addr == REG_STATUS &&
                   reg_wdata[STAT_KEYERR]) begin
        key_err_q <= 1'b0;
      end
    end
  end

  // Array port: the erase sweep and the program write in its start cycle own it, the CPU otherwise.
  assign hit = cpu_req.valid &&
               cpu_req.addr[17:15] == (seg1_q ? SEG1_TAG : SEG0_TAG);
  assign blocked = secure_q && !cpu_req.from_flash;
  assign cpu_ready = !busy;
  assign take = hit && !busy;
  assign arr_we = (start_ok && !start_erase) || state_q == ST_ERASE;
  assign arr_addr = state_q == ST_ERASE ? ptr_q :
                    start_ok ? paddr_q : cpu_req.addr[WADDR_W+1:2];
  assign arr_wdata = state_q == ST_ERASE ? ERASED_WORD : pdata_q;

  flash_array u_array (
    .clk_sys(clk_sys),
    .we(arr_we),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  // Access bookkeeping for the answer in the next cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_pend_q <= 1'b0;
      rsp_blk_q <= 1'b0;
      rsp_hi_q <= 1'b0;
      rsp_fetch_q <= 1'b0;
    end else begin
      rsp_pend_q <= take;
      rsp_blk_q <= blocked;
      rsp_hi_q <= cpu_req.addr[1];
      rsp_fetch_q <= cpu_req.fetch;
    end
  end

  // Answer: full word for fetches, selected half for operand reads.
  always_comb begin
    cpu_rsp.valid = rsp_pend_q;
    cpu_rsp.blocked = rsp_pend_q && rsp_blk_q;
    cpu_rsp.fetch_data = (rsp_pend_q && !rsp_blk_q && rsp_fetch_q) ?
                         arr_rdata : '0;
    cpu_rsp.operand = (rsp_pend_q && !rsp_blk_q) ?
                      (rsp_hi_q ? arr_rdata[31:16] : arr_rdata[15:0]) :
                      16'h0000;
  end

  assign stat = '{key_err: key_err_q, secure: secure_q, seg1: seg1_q,
                  locked: locked_q, wem: wem_q, busy: busy,
                  vpp_good: vpp_good_q, done: done_q};

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !reg_re) begin
      reg_rdata <= 16'h0000;
    end else begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata <= {11'h000, 1'b0, erase_q, bank_q, seg1_q};
        REG_TIMER: reg_rdata <= timer_q;
        REG_PDATA_LO: reg_rdata <= pdata_q[15:0];
        REG_PDATA_HI: reg_rdata <= pdata_q[31:16];
        REG_PADDR: reg_rdata <= {3'h0, paddr_q};
        REG_STATUS: reg_rdata <= {8'h00, stat};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_lock_holds: assert property (locked_q |=> $stable(seg1_q))
    else $error("Segment map changed after lock.");
  a_reset_seg0: assert property ($fell(sys_rst) |-> !seg1_q)
    else $error("Flash not in segment 0 after reset.");
  a_seg1_early: assert property (reg_we && reg_addr == REG_CTRL &&
      !locked_q && !end_of_init_instruction |=> seg1_q == $past(reg_wdata[0]))
    else $error("Segment move refused before lock.");
  a_no_key_start: assert property (start && !wem_q |=> !busy && key_err_q)
    else $error("Start without key sequence was not rejected.");
  a_done_clear: assert property (start_ok |=> !done_q && busy)
    else $error("Done not cleared at cycle start.");
  a_done_set: assert property (cyc_end |=> done_q && !busy)
    else $error("Done not set at cycle end.");
  a_vpp_drop: assert property (busy && !vpp_ok |=> !vpp_good_q)
    else $error("Voltage flag kept after a bad voltage.");
  a_erase_range: assert property (state_q == ST_ERASE |->
      ptr_q >= bank_lo && ptr_q <= bank_hi && arr_we)
    else $error("Erase left the selected bank.");
  localparam int SWEEP3_LAST = (BANK3_END - BANK2_END) / 4 - 1; // Prescaler.
  a_erase_walk: assert property (state_q == ST_ERASE && bank_q == 2'd3 |->
      (ptr_q == bank_hi) == (pre_q == 12'(SWEEP3_LAST)))
    else $error("Bank 3 sweep length wrong.");
  a_read_wait: assert property (busy |=> !rsp_pend_q)
    else $error("Array read answered during a cycle.");
  a_secure_blk: assert property (take && secure_q && !cpu_req.from_flash
      |=> cpu_rsp.blocked && cpu_rsp.operand == 16'h0000)
    else $error("Access from outside the array not blocked.");
  a_secdis_gate: assert property (wem_q && strap_taken_q && secure_q
      |=> secure_q)
    else $error("Security dropped in write/erase mode.");
  a_operand_sel: assert property (rsp_pend_q && !rsp_blk_q && rsp_hi_q
      |-> cpu_rsp.operand == arr_rdata[31:16])
    else $error("Upper operand half not selected.");
  a_fetch_word: assert property (rsp_pend_q && !rsp_blk_q && rsp_fetch_q
      |-> cpu_rsp.fetch_data == arr_rdata)
    else $error("Fetch did not return the full word.");

  c_erase: cover property (start_erase ##[1:1000] state_q == ST_TIME);
  c_program: cover property (start_ok && !start_erase);
  c_remap: cover property (seg1_q && locked_q);
  c_blocked: cover property (cpu_rsp.blocked);
endmodule // flash_ctrl

/* File: cpu_model.sv */
// Behavioural model of the CPU fetch and operand bus.
`timescale 1ns/10ps
module cpu_model
  import flash_pkg::*;
(
  input wire logic clk_sys,
  input wire logic cpu_ready,
  input wire flash_pkg::cpu_rsp_s cpu_rsp,
  output flash_pkg::cpu_req_s cpu_req
);
  initial cpu_req = '0;

  // Holds a request until ready is seen at an edge, then shows the inverted
  // address so that a stale address is never taken for a live one.
  task automatic access(input logic f, input logic ff, input logic [17:0] a,
                        output cpu_rsp_s r);
    int n;
    n = 0;
    @(posedge clk_sys);
    cpu_req <= '{valid: 1'b1, fetch: f, from_flash: ff, addr: a};
    do begin
      @(posedge clk_sys);
      n++;
    end while (cpu_ready !== 1'b1 && n < 8000);
    cpu_req <= '{valid: 1'b0, fetch: f, from_flash: ff, addr: ~a};
    #1;
    r = cpu_rsp;
  endtask
endmodule // cpu_model

/* File: testbench.sv */
// Self-checking bench for the flash map and erase control.
`timescale 1ns/10ps
module testbench;
  import flash_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic eoi = 1'b0;
  logic vpp_ok = 1'b1;
  logic sec_strap = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic reg_from_flash = 1'b0;
  logic [15:0] reg_rdata;
  logic cpu_ready;
  cpu_req_s cpu_req;
  cpu_rsp_s cpu_rsp;
  cpu_rsp_s r;
  logic [15:0] rd;
  int n_errors = 0;
  int checks = 0;
  int n;

  // Free-running 100 MHz system clock.
  initial forever #5 clk_sys = ~clk_sys;

  flash_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_req(cpu_req),
    .cpu_ready(cpu_ready), .cpu_rsp(cpu_rsp),
    .end_of_init_instruction(eoi), .vpp_ok(vpp_ok), .sec_strap(sec_strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_from_flash(reg_from_flash),
    .reg_rdata(reg_rdata));

  cpu_model i_cpu (.clk_sys(clk_sys), .cpu_ready(cpu_ready),
    .cpu_rsp(cpu_rsp), .cpu_req(cpu_req));

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle register write; the strobe drops at the next edge.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rrd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic acc(input logic f, input logic ff, input logic [17:0] a);
    i_cpu.access(f, ff, a, r);
  endtask

  // Loads one word and starts it; the CPU port must stall at once.
  task automatic prog(input logic [12:0] wa, input logic [31:0] d);
    wr(REG_PADDR, {3'h0, wa});
    wr(REG_PDATA_LO, d[15:0]);
    wr(REG_PDATA_HI, d[31:16]);
    wr(REG_CTRL, 16'h0010);
    #1;
    check(cpu_ready, 1'b0);
  endtask

  // Bounded wait for the end of a cycle, counting clocks.
  task automatic wait_done();
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cpu_ready !== 1'b1 && n < 8000);
    check(cpu_ready, 1'b1);
  endtask

  // Watchdog sized well above the four timed cycles of the run.
  initial begin
    #600000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence; the timer is kept at one or two ticks to stay short.
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rrd(REG_STATUS);
    check(rd, 16'h0040);
    rrd(4'h8);
    check(rd, 16'h0000);
    acc(1'b1, 1'b0, 18'h00000);
    check({r.valid, r.blocked, r.fetch_data}, {2'b11, 32'h0});
    wr(REG_SECDIS, 16'h0001);
    wr(REG_CTRL, 16'h0010);
    rrd(REG_STATUS);
    check(rd, 16'h00c0);
    wr(REG_STATUS, 16'h0080);
    wr(REG_KEY, KEY_FIRST);
    wr(REG_KEY, KEY_SECOND);
    reg_from_flash <= 1'b1;
    wr(REG_SECDIS, 16'h0001);
    rrd(REG_STATUS);
    check(rd, 16'h0048);
    wr(REG_TIMER, 16'h0001);
    prog(13'h0000, 32'h12345678);
    wait_done();
    check(36'((n + 50) / 100), 36'd25);
    rrd(REG_STATUS);
    check(rd, 16'h004b);
    acc(1'b1, 1'b1, 18'h00000);
    check({r.valid, r.fetch_data}, {1'b1, 32'h12345678});
    acc(1'b0, 1'b1, 18'h00002);
    check({r.valid, r.operand}, {1'b1, 16'h1234});
    acc(1'b0, 1'b1, 18'h00000);
    check({r.fetch_data, r.operand}, {32'h0, 16'h5678});
    // A voltage dip in mid-cycle must spoil the good-voltage flag.
    wr(REG_TIMER, 16'h0002);
    prog(13'h1dff, 32'h0badf00d);
    rrd(REG_STATUS);
    check(rd, 16'h004e);
    @(posedge clk_sys);
    vpp_ok <= 1'b0;
    @(posedge clk_sys);
    vpp_ok <= 1'b1;
    wait_done();
    check(36'((n + 50) / 100), 36'd50);
    rrd(REG_STATUS);
    check(rd, 16'h0049);
    wr(REG_TIMER, 16'h0001);
    prog(13'h1e00, 32'hcafe5a5a);
    wait_done();
    wr(REG_CTRL, 16'h001e);
    wait_done();
    acc(1'b1, 1'b1, 18'h077fc);
    check(r.fetch_data, 32'h0badf00d);
    acc(1'b1, 1'b1, 18'h07800);
    check(r.fetch_data, 32'hffffffff);
    acc(1'b1, 1'b1, 18'h00000);
    check(r.fetch_data, 32'h12345678);
    wr(REG_KEY, 16'h0000);
    wr(REG_SECDIS, 16'h0001);
    rrd(REG_STATUS);
    check(rd, 16'h0003);
    reg_from_flash <= 1'b0;
    acc(1'b1, 1'b0, 18'h10000);
    check(r.valid, 1'b0);
    wr(REG_CTRL, 16'h0001);
    acc(1'b1, 1'b0, 18'h10000);
    check({r.valid, r.fetch_data}, {1'b1, 32'h12345678});
    acc(1'b1, 1'b0, 18'h00000);
    check(r.valid, 1'b0);
    @(posedge clk_sys);
    eoi <= 1'b1;
    @(posedge clk_sys);
    eoi <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    rrd(REG_STATUS);
    check(rd, 16'h0033);
    report_and_stop();
  end
endmodule // testbench
